// ===== hdl/np_regs_pkg.sv
// constants for the autonegotiation next-page register bank
package np_regs_pkg;
  // =====================================================
  // register addresses within the autonegotiation device
  localparam logic [15:0] addr_np_tx_word_low = 16'h0208;
  localparam logic [15:0] addr_np_tx_word_mid = 16'h0209;
  localparam logic [15:0] addr_np_tx_word_high = 16'h020A;
  localparam logic [15:0] addr_partner_np_word_low = 16'h020B;
  localparam logic [15:0] addr_partner_np_word_mid = 16'h020C;
  localparam logic [15:0] addr_partner_np_word_high = 16'h020D;
  // =====================================================
  // reset values
  localparam logic [15:0] rst_np_tx_word_low = 16'h2001;
  localparam logic [15:0] rst_np_tx_word_mid = 16'h0000;
  localparam logic [15:0] rst_np_tx_word_high = 16'h0000;
  localparam logic [15:0] rst_partner_word = 16'h0000;
  // =====================================================
  // field positions in the low words
  localparam int bit_more_pages = 15;
  localparam int bit_acknowledge = 14;
  localparam int bit_encoding = 13;
  localparam int bit_can_comply = 12;
  localparam int bit_toggle = 11;
  localparam int code_msb = 10;
  // =====================================================
  // message codes
  localparam logic [10:0] code_null = 11'h001;
  localparam logic [10:0] code_oui_tagged = 11'h005;
  localparam logic [10:0] code_device_id = 11'h006;
  // software-writable bits of the transmit low word
  localparam logic [15:0] tx_low_write_mask = 16'hB7FF;
endpackage : np_regs_pkg

// ===== hdl/autoneg_next_page_regs.sv
// next-page transmit and link-partner registers of the autonegotiation device
`timescale 1ns/1ps
module autoneg_next_page_regs (
  input wire logic clk, // 25 MHz core clock
  input wire logic nrst, // asynchronous reset, active low
  input wire logic an_reset, // autonegotiation soft reset, active high, level held for any number of cycles
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [15:0] reg_addr, // register address in the device
  input wire logic [15:0] reg_wdata, // write data
  output logic [15:0] reg_rdata, // read data, registered
  output logic reg_hit, // address belongs to this bank
  input wire logic tx_page_acknowledge, // acknowledge bit from arbiter
  output logic [47:0] tx_page, // committed page, toggle bit zero
  output logic tx_page_commit, // one-cycle pulse on page commit
  input wire logic [47:0] partner_page // live received partner page
);
  // =====================================================
  // register state
  logic [15:0] tx_low;
  logic [15:0] tx_mid;
  logic [15:0] tx_high;
  logic [15:0] lp_mid;
  logic [15:0] lp_high;
  logic [47:0] next_tx_page;
  logic [15:0] next_tx_low;
  logic [15:0] next_tx_mid;
  logic [15:0] next_tx_high;
  logic [15:0] next_lp_mid;
  logic [15:0] next_lp_high;
  logic [15:0] next_rdata;
  logic next_commit;
  logic [15:0] tx_low_view;
  logic [15:0] lp_low_view;

  // acknowledge comes from the arbiter, toggle always reads zero
  always_comb begin
    tx_low_view = tx_low & np_regs_pkg::tx_low_write_mask;
    tx_low_view[np_regs_pkg::bit_acknowledge] = tx_page_acknowledge;
    lp_low_view = partner_page[15:0];
  end

  always_comb begin
    next_tx_low = tx_low;
    next_tx_mid = tx_mid;
    next_tx_high = tx_high;
    next_lp_mid = lp_mid;
    next_lp_high = lp_high;
    next_tx_page = tx_page;
    next_commit = 1'b0;
    if (an_reset) begin
      next_tx_low = np_regs_pkg::rst_np_tx_word_low;
      next_tx_mid = np_regs_pkg::rst_np_tx_word_mid;
      next_tx_high = np_regs_pkg::rst_np_tx_word_high;
    end else if (reg_wr) begin
      if (reg_addr == np_regs_pkg::addr_np_tx_word_low) begin
        // masked so the acknowledge and toggle bits never store
        next_tx_low = reg_wdata & np_regs_pkg::tx_low_write_mask;
        // relies on mid and high already written by software
        next_tx_page = {tx_high, tx_mid, next_tx_low};
        next_commit = 1'b1;
      end else if (reg_addr == np_regs_pkg::addr_np_tx_word_mid) begin
        next_tx_mid = reg_wdata;
      end else if (reg_addr == np_regs_pkg::addr_np_tx_word_high) begin
        next_tx_high = reg_wdata;
      end
    end
    if (reg_rd && reg_addr == np_regs_pkg::addr_partner_np_word_low) begin
      next_lp_mid = partner_page[31:16];
      next_lp_high = partner_page[47:32];
    end
  end

  always_comb begin
    reg_hit = (reg_addr >= np_regs_pkg::addr_np_tx_word_low) &&
              (reg_addr <= np_regs_pkg::addr_partner_np_word_high);
    next_rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        np_regs_pkg::addr_np_tx_word_low: next_rdata = tx_low_view;
        np_regs_pkg::addr_np_tx_word_mid: next_rdata = tx_mid;
        np_regs_pkg::addr_np_tx_word_high: next_rdata = tx_high;
        np_regs_pkg::addr_partner_np_word_low: next_rdata = lp_low_view;
        np_regs_pkg::addr_partner_np_word_mid: next_rdata = lp_mid;
        np_regs_pkg::addr_partner_np_word_high: next_rdata = lp_high;
        default: next_rdata = 16'h0000;
      endcase
    end else begin
      next_rdata = reg_rdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_low <= np_regs_pkg::rst_np_tx_word_low;
      tx_mid <= np_regs_pkg::rst_np_tx_word_mid;
      tx_high <= np_regs_pkg::rst_np_tx_word_high;
      lp_mid <= np_regs_pkg::rst_partner_word;
      lp_high <= np_regs_pkg::rst_partner_word;
      tx_page <= {np_regs_pkg::rst_np_tx_word_high, np_regs_pkg::rst_np_tx_word_mid,
                  np_regs_pkg::rst_np_tx_word_low};
      tx_page_commit <= 1'b0;
      reg_rdata <= 16'h0000;
    end else begin
      tx_low <= next_tx_low;
      tx_mid <= next_tx_mid;
      tx_high <= next_tx_high;
      lp_mid <= next_lp_mid;
      lp_high <= next_lp_high;
      tx_page <= next_tx_page;
      tx_page_commit <= next_commit;
      reg_rdata <= next_rdata;
    end
  end

  // =====================================================
  // checks on the transmit words
  // soft reset must win over a write in the same cycle
  a_reset_null_page: assert property (@(posedge clk) disable iff (!nrst)
    an_reset |=> tx_low == np_regs_pkg::rst_np_tx_word_low &&
    tx_mid == np_regs_pkg::rst_np_tx_word_mid && tx_high == np_regs_pkg::rst_np_tx_word_high)
    else $error("autoneg reset did not restore null page");
  a_ack_read_only: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && !an_reset && reg_addr == np_regs_pkg::addr_np_tx_word_low |=>
    tx_low[np_regs_pkg::bit_acknowledge] == 1'b0)
    else $error("acknowledge bit stored from software");
  a_ack_read_view: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == np_regs_pkg::addr_np_tx_word_low |=>
    reg_rdata[np_regs_pkg::bit_acknowledge] == $past(tx_page_acknowledge))
    else $error("acknowledge bit not shown on low word read");
  a_toggle_zero: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == np_regs_pkg::addr_np_tx_word_low |=>
    reg_rdata[np_regs_pkg::bit_toggle] == 1'b0)
    else $error("toggle bit read nonzero");
  a_code_write: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && !an_reset && reg_addr == np_regs_pkg::addr_np_tx_word_low |=>
    tx_low[np_regs_pkg::code_msb:0] == $past(reg_wdata[np_regs_pkg::code_msb:0]) &&
    tx_low[np_regs_pkg::bit_more_pages] == $past(reg_wdata[np_regs_pkg::bit_more_pages]))
    else $error("code or request bit not stored");
  a_encoding_write: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && !an_reset && reg_addr == np_regs_pkg::addr_np_tx_word_low |=>
    tx_low[np_regs_pkg::bit_encoding] == $past(reg_wdata[np_regs_pkg::bit_encoding]))
    else $error("encoding bit not stored");
  a_comply_write: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && !an_reset && reg_addr == np_regs_pkg::addr_np_tx_word_low |=>
    tx_low[np_regs_pkg::bit_can_comply] == $past(reg_wdata[np_regs_pkg::bit_can_comply]))
    else $error("can-comply bit not stored");
  a_mid_write: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && !an_reset && reg_addr == np_regs_pkg::addr_np_tx_word_mid |=>
    tx_mid == $past(reg_wdata))
    else $error("mid word not stored");
  a_high_write: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && !an_reset && reg_addr == np_regs_pkg::addr_np_tx_word_high |=>
    tx_high == $past(reg_wdata))
    else $error("high word not stored");
  a_tx_mid_read: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == np_regs_pkg::addr_np_tx_word_mid |=>
    reg_rdata == $past(tx_mid))
    else $error("mid word read mismatch");
  a_tx_high_read: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == np_regs_pkg::addr_np_tx_word_high |=>
    reg_rdata == $past(tx_high))
    else $error("high word read mismatch");
  a_rdata_hold: assert property (@(posedge clk) disable iff (!nrst)
    !reg_rd |=>
    $stable(reg_rdata))
    else $error("read data changed without a read");
  // the page only moves on a committed low write
  a_page_commit: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && !an_reset && reg_addr == np_regs_pkg::addr_np_tx_word_low |=>
    tx_page_commit && tx_page[47:32] == $past(tx_high) &&
    tx_page[31:16] == $past(tx_mid) && tx_page[15:0] == tx_low)
    else $error("page not committed on low write");
  a_commit_quiet: assert property (@(posedge clk) disable iff (!nrst)
    !(reg_wr && !an_reset && reg_addr == np_regs_pkg::addr_np_tx_word_low) |=>
    !tx_page_commit && $stable(tx_page))
    else $error("page changed without a low write");
  a_page_flags_zero: assert property (@(posedge clk) disable iff (!nrst)
    tx_page[np_regs_pkg::bit_toggle] == 1'b0 &&
    tx_page[np_regs_pkg::bit_acknowledge] == 1'b0)
    else $error("committed page carries toggle or acknowledge");
  // =====================================================
  // checks on the partner words
  // latched words must not drift between two low reads
  a_partner_low: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == np_regs_pkg::addr_partner_np_word_low |=>
    reg_rdata == $past(partner_page[15:0]))
    else $error("partner low word mismatch");
  a_partner_code: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == np_regs_pkg::addr_partner_np_word_low |=>
    reg_rdata[np_regs_pkg::bit_encoding] == $past(partner_page[np_regs_pkg::bit_encoding]) &&
    reg_rdata[np_regs_pkg::code_msb:0] == $past(partner_page[np_regs_pkg::code_msb:0]))
    else $error("partner encoding or code mismatch");
  a_partner_latch: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == np_regs_pkg::addr_partner_np_word_low |=>
    lp_mid == $past(partner_page[31:16]) && lp_high == $past(partner_page[47:32]))
    else $error("partner words not latched on low read");
  a_partner_hold: assert property (@(posedge clk) disable iff (!nrst)
    !(reg_rd && reg_addr == np_regs_pkg::addr_partner_np_word_low) |=>
    $stable(lp_mid) && $stable(lp_high))
    else $error("partner latch changed without a low read");
  a_refused_write: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && reg_addr == np_regs_pkg::addr_partner_np_word_mid |=>
    $stable(lp_mid))
    else $error("partner mid word took a write");
  a_partner_mid_read: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == np_regs_pkg::addr_partner_np_word_mid |=>
    reg_rdata == $past(lp_mid))
    else $error("partner mid read not the latched value");
  a_partner_high_read: assert property (@(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == np_regs_pkg::addr_partner_np_word_high |=>
    reg_rdata == $past(lp_high))
    else $error("partner high read not the latched value");
endmodule : autoneg_next_page_regs

// ===== test/link_partner_model.sv
// link partner model: presents the next page it sends over the wire
`timescale 1ns/1ps
module link_partner_model (
  input wire logic clk, // core clock
  input wire logic nrst, // reset, active low
  input wire logic [47:0] page_in, // page the partner sends next
  output logic [47:0] page // page as received, one cycle late
);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) page <= 48'h0000_0000_0000;
    else page <= page_in;
  end
endmodule : link_partner_model

// ===== test/test_autoneg_next_page_regs.sv
// self-checking bench for the next-page register bank
`timescale 1ns/1ps
module test_autoneg_next_page_regs;
  logic clk = 1'b0, nrst = 1'b0, an_reset = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ack = 1'b0;
  logic commit, hit;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata;
  logic [47:0] tx_page, lp_page, lp_in = 48'h0000_0000_0000;
  logic [47:0] m_page = 48'h0000_0000_2001;
  logic [15:0] m_tx [3] = '{16'h2001, 16'h0000, 16'h0000};
  logic [15:0] m_lat [2] = '{16'h0000, 16'h0000};
  logic [10:0] codes [3] = '{np_regs_pkg::code_null, np_regs_pkg::code_oui_tagged,
    np_regs_pkg::code_device_id};
  int err_count = 0, num_checks = 0, cyc = 0, seed = 1;
  always #20 clk = ~clk;
  autoneg_next_page_regs i_autoneg_next_page_regs (.clk(clk), .nrst(nrst),
    .an_reset(an_reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_hit(hit), .tx_page_acknowledge(ack),
    .tx_page(tx_page), .tx_page_commit(commit), .partner_page(lp_page));
  link_partner_model i_link_partner_model (.clk(clk), .nrst(nrst), .page_in(lp_in),
    .page(lp_page));
  // =====================================================
  // checking and bus tasks
  task automatic compare(string what, logic [47:0] exp, logic [47:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : compare
  task summarize;
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  function automatic logic [15:0] m_rd(logic [15:0] a);
    case (a)
      16'h0208: return m_tx[0] | {1'b0, ack, 14'h0000};
      16'h0209, 16'h020A: return m_tx[a[1:0]];
      16'h020B: return lp_page[15:0];
      16'h020C, 16'h020D: return m_lat[a[0]];
      default: return 16'h0000;
    endcase
  endfunction : m_rd
  task automatic rd(logic [15:0] a);
    logic [15:0] exp;
    @(posedge clk);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    exp = m_rd(a);
    // the latch takes the page seen at the read edge, not a later one
    if (a == 16'h020B) m_lat = '{lp_page[31:16], lp_page[47:32]};
    #1;
    compare("rdata", {32'h0000_0000, exp}, {32'h0000_0000, rdata});
    compare("hit", {47'h0, a inside {[16'h0208:16'h020D]}}, {47'h0, hit});
  endtask : rd
  task automatic wr(logic [15:0] a, logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a inside {16'h0208, 16'h0209, 16'h020A}) m_tx[a[1:0]] = a[1:0] == 2'h0 ? d & 16'hB7FF : d;
    if (a == 16'h0208) m_page = {m_tx[2], m_tx[1], m_tx[0]};
    #1;
    compare("commit", {47'h0, a == 16'h0208}, {47'h0, commit});
    compare("tx_page", m_page, tx_page);
  endtask : wr
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      summarize();
    end
  end
  // =====================================================
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    compare("tx_page", m_page, tx_page);
    for (int a = 16'h0207; a <= 16'h020E; a++) rd(16'(a));
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      ack <= 1'($random(seed));
      lp_in <= {16'($random(seed)), 32'($random(seed))};
      wr(16'h0209, 16'($random(seed)));
      wr(16'h020A, 16'($random(seed)));
      wr(16'h0208, {5'($random(seed)), codes[i % 3]});
      wr(16'h020C, 16'($random(seed)));
      rd(16'h0208);
      rd(16'h020B);
      @(posedge clk);
      lp_in <= {16'($random(seed)), 32'($random(seed))};
      rd(16'h0209);
      rd(16'h020C);
      rd(16'h020D);
    end
    @(posedge clk);
    an_reset <= 1'b1;
    // a write that meets the soft reset is lost
    wr(16'h0209, 16'hFFFF);
    @(posedge clk);
    an_reset <= 1'b0;
    m_tx = '{16'h2001, 16'h0000, 16'h0000};
    for (int a = 16'h0208; a <= 16'h020A; a++) rd(16'(a));
    compare("tx_page", m_page, tx_page);
    // mid-run power-up reset returns the committed page to the null page and clears the latches
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    m_page = 48'h0000_0000_2001;
    m_lat = '{16'h0000, 16'h0000};
    compare("tx_page", m_page, tx_page);
    rd(16'h020C);
    rd(16'h020D);
    rd(16'h0208);
    summarize();
  end
endmodule : test_autoneg_next_page_regs
